// file: iefl_defs.svh
// Offsets, bit positions, reset values and constants of the block
`ifndef IEFL_DEFS_SVH
`define IEFL_DEFS_SVH
`define IEFL_OFF_CTRL 8'h00
`define IEFL_OFF_PEN1 8'h04
`define IEFL_OFF_PFLG 8'h08
`define IEFL_OFF_PSEL 8'h0c
`define IEFL_OFF_TCNT 8'h10
`define IEFL_OFF_STAT 8'h14
`define IEFL_OFF_MASK 8'h18
`define IEFL_BIT_GLOB 7
`define IEFL_BIT_PERI 6
`define IEFL_BIT_T0EN 5
`define IEFL_BIT_EXIE 4
`define IEFL_BIT_PCIE 3
`define IEFL_BIT_T0FL 2
`define IEFL_BIT_EXIF 1
`define IEFL_BIT_PCIF 0
`define IEFL_PEN1_MSB 5
`define IEFL_EV_T0 0
`define IEFL_EV_EX 1
`define IEFL_EV_PC 2
`define IEFL_CTRL_RST 8'h00
`define IEFL_PEN1_RST 6'h00
`define IEFL_PSEL_RST 8'h00
`define IEFL_EV_RST 3'h0
`define IEFL_TCNT_TOP 8'hff
`define IEFL_TCNT_ONE 8'h01
`define IEFL_VECTOR 13'h0004
`define IEFL_ZERO32 32'h0000_0000
`define IEFL_ZERO24 24'h00_0000
`define IEFL_ZERO2 2'h0
`define IEFL_ZERO5 5'h00
`endif

// file: iefl_pkg.sv
// Types of the interrupt enable and flag block
package iefl_pkg;
    typedef enum logic [2:0] {
        IEFL_IDLE = 3'h1,
        IEFL_ENTER = 3'h2,
        IEFL_ISR = 3'h4
    } iefl_state_e;
    typedef struct packed {
        logic [7:0] adr;
        logic [31:0] dat;
        logic we;
        logic lane0;
    } iefl_wb_req_s;
    typedef struct packed {
        logic push;
        logic load;
        logic [12:0] ret_addr;
    } iefl_take_s;
endpackage

// file: iefl_top.sv
// Interrupt enable and flag logic with a classic Wishbone register slave
//
// Behaviour
// - Global enable bit 7 lets enabled interrupts through; cleared blocks core_irq_o, but irq_o is not gated by it
// - Peripheral enable bit 6 gates every peripheral interrupt
// - Bit 5 enables the timer-0 overflow interrupt
// - Bit 4 enables the external pin interrupt
// - Bit 3 enables pin change; each pin also needs its select bit
// - Timer-0 rollover sets flag bit 2; it holds until software clears
// - Reset leaves timer-0 count untouched; software loads it first
// - Valid external edge sets flag bit 1; only software clears it
// - Flag bit 0 shows an enabled pin changed state
// - Flags set whatever their enables or the global enable hold
// - Peripheral enable bits 7 and 6 ignore writes and read zero
// - Peripheral bit 5 enables bus collision, bit 4 serial transfer
// - Peripheral bit 3 enables capture/compare two, bit 2 one
// - Peripheral bit 1 enables timer2 match, bit 0 timer1
// - Taking an interrupt clears global enable, pushes return, loads vector
// - Reset clears global enable; return from interrupt sets it again
//
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`include "iefl_defs.svh"

module iefl_top
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic timer0_tick_i,
    input wire logic ext_pin_i,
    input wire logic ext_edge_rising_i,
    input wire logic [7:0] pin_change_pins_i,
    input wire logic [5:0] periph_flags_i,
    input wire logic irq_take_i,
    input wire logic irq_return_i,
    input wire logic [12:0] return_addr_i,
    output logic core_irq_o,
    output logic stack_push_o,
    output logic [12:0] stack_push_addr_o,
    output logic pc_load_o,
    output logic [12:0] pc_vector_o,
    output logic irq_o
);

    function automatic logic iefl_hit(input logic [7:0] a,
                                      input logic [7:0] off);
        iefl_hit = (a == off);
    endfunction

    iefl_pkg::iefl_wb_req_s req;
    iefl_pkg::iefl_take_s take_d;
    iefl_pkg::iefl_state_e state_q;
    iefl_pkg::iefl_state_e state_d;
    logic acc;
    logic wr;
    logic [7:0] ctrl_q;
    logic [5:0] pen1_q;
    logic [7:0] psel_q;
    logic [7:0] tcnt_q;
    logic [2:0] ev_stat_q;
    logic [2:0] ev_mask_q;
    logic [7:0] pins_prev_q;
    logic [7:0] pin_chg;
    logic ext_prev_q;
    logic t0_roll;
    logic ext_edge;
    logic pc_event;
    logic [2:0] ev_now;
    logic core_req;
    logic t0_req;
    logic ext_req;
    logic pc_req;
    logic ev_irq;
    logic periph_req;
    logic take;
    logic [31:0] rd_d;

    assign req.adr = adr_i;
    assign req.dat = dat_i;
    assign req.we = we_i;
    assign req.lane0 = sel_i[0];
    assign acc = cyc_i & stb_i & ~ack_o;
    // Writes land on the edge where the master sees ack
    assign wr = cyc_i & stb_i & ack_o & req.we & req.lane0;

    // Event detection
    assign t0_roll = timer0_tick_i & (tcnt_q == `IEFL_TCNT_TOP);
    assign ext_edge = ext_edge_rising_i ? (ext_pin_i & ~ext_prev_q)
                                        : (~ext_pin_i & ext_prev_q);

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_pin
            // Only selected pins take part
            assign pin_chg[gi] = psel_q[gi] &
                (pin_change_pins_i[gi] ^ pins_prev_q[gi]);
        end
    endgenerate

    assign pc_event = |pin_chg;
    assign ev_now = {pc_event, ext_edge, t0_roll};
    // Level interrupt while an unmasked status bit is set
    assign ev_irq = |(ev_stat_q & ev_mask_q);

    // Request combining
    assign periph_req = ctrl_q[`IEFL_BIT_PERI] &
                        (|(pen1_q & periph_flags_i));
    assign t0_req = ctrl_q[`IEFL_BIT_T0EN] & ctrl_q[`IEFL_BIT_T0FL];
    assign ext_req = ctrl_q[`IEFL_BIT_EXIE] & ctrl_q[`IEFL_BIT_EXIF];
    assign pc_req = ctrl_q[`IEFL_BIT_PCIE] & ctrl_q[`IEFL_BIT_PCIF];
    assign core_req = ctrl_q[`IEFL_BIT_GLOB] &
                      (periph_req | t0_req | ext_req | pc_req);

    assign take = (state_q == iefl_pkg::IEFL_IDLE) & irq_take_i & core_irq_o;

    // Dispatch sequence
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            iefl_pkg::IEFL_IDLE:
            begin
                if (take)
                begin
                    state_d = iefl_pkg::IEFL_ENTER;
                end
            end
            iefl_pkg::IEFL_ENTER:
            begin
                state_d = iefl_pkg::IEFL_ISR;
            end
            iefl_pkg::IEFL_ISR:
            begin
                if (irq_return_i)
                begin
                    state_d = iefl_pkg::IEFL_IDLE;
                end
            end
            default:
            begin
                state_d = iefl_pkg::IEFL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= iefl_pkg::IEFL_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign take_d.push = take;
    assign take_d.load = take;
    assign take_d.ret_addr = return_addr_i;

    // Stack push and vector load pulses
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stack_push_o <= 1'b0;
            pc_load_o <= 1'b0;
            stack_push_addr_o <= 13'h0000;
            pc_vector_o <= 13'h0000;
        end
        else
        begin
            stack_push_o <= take_d.push;
            pc_load_o <= take_d.load;
            if (take)
            begin
                stack_push_addr_o <= take_d.ret_addr;
                pc_vector_o <= `IEFL_VECTOR;
            end
        end
    end

    // Control register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= `IEFL_CTRL_RST;
        end
        else
        begin
            if (wr && iefl_hit(req.adr, `IEFL_OFF_CTRL))
            begin
                ctrl_q <= req.dat[7:0];
            end
            if (take)
            begin
                ctrl_q[`IEFL_BIT_GLOB] <= 1'b0;
            end
            else if (irq_return_i)
            begin
                ctrl_q[`IEFL_BIT_GLOB] <= 1'b1;
            end
            // Hardware set wins over a software clear
            if (t0_roll)
            begin
                ctrl_q[`IEFL_BIT_T0FL] <= 1'b1;
            end
            if (ext_edge)
            begin
                ctrl_q[`IEFL_BIT_EXIF] <= 1'b1;
            end
            if (pc_event)
            begin
                ctrl_q[`IEFL_BIT_PCIF] <= 1'b1;
            end
        end
    end

    // Peripheral enable and pin select registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pen1_q <= `IEFL_PEN1_RST;
            psel_q <= `IEFL_PSEL_RST;
        end
        else
        begin
            if (wr && iefl_hit(req.adr, `IEFL_OFF_PEN1))
            begin
                // Top two bits are dropped
                pen1_q <= req.dat[`IEFL_PEN1_MSB:0];
            end
            if (wr && iefl_hit(req.adr, `IEFL_OFF_PSEL))
            begin
                psel_q <= req.dat[7:0];
            end
        end
    end

    // Timer-0 count keeps its value through reset
    always_ff @(posedge clk_i)
    begin
        if (wr && iefl_hit(req.adr, `IEFL_OFF_TCNT))
        begin
            tcnt_q <= req.dat[7:0];
        end
        else if (timer0_tick_i)
        begin
            tcnt_q <= tcnt_q + `IEFL_TCNT_ONE;
        end
    end

    // Input history for edge and change detection
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_prev_q <= 1'b0;
            pins_prev_q <= 8'h00;
        end
        else
        begin
            ext_prev_q <= ext_pin_i;
            pins_prev_q <= pin_change_pins_i;
        end
    end

    // Sticky event status, write one to clear, and mask
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ev_stat_q <= `IEFL_EV_RST;
            ev_mask_q <= `IEFL_EV_RST;
        end
        else
        begin
            if (wr && iefl_hit(req.adr, `IEFL_OFF_STAT))
            begin
                ev_stat_q <= (ev_stat_q & ~req.dat[2:0]) | ev_now;
            end
            else
            begin
                ev_stat_q <= ev_stat_q | ev_now;
            end
            if (wr && iefl_hit(req.adr, `IEFL_OFF_MASK))
            begin
                ev_mask_q <= req.dat[2:0];
            end
        end
    end

    // Request outputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            core_irq_o <= 1'b0;
            irq_o <= 1'b0;
        end
        else
        begin
            core_irq_o <= core_req;
            irq_o <= ev_irq;
        end
    end

    // Read decode
    always_comb
    begin
        rd_d = `IEFL_ZERO32;
        if (iefl_hit(req.adr, `IEFL_OFF_CTRL))
        begin
            rd_d = {`IEFL_ZERO24, ctrl_q};
        end
        else if (iefl_hit(req.adr, `IEFL_OFF_PEN1))
        begin
            rd_d = {`IEFL_ZERO24, `IEFL_ZERO2, pen1_q};
        end
        else if (iefl_hit(req.adr, `IEFL_OFF_PFLG))
        begin
            rd_d = {`IEFL_ZERO24, `IEFL_ZERO2, periph_flags_i};
        end
        else if (iefl_hit(req.adr, `IEFL_OFF_PSEL))
        begin
            rd_d = {`IEFL_ZERO24, psel_q};
        end
        else if (iefl_hit(req.adr, `IEFL_OFF_TCNT))
        begin
            rd_d = {`IEFL_ZERO24, tcnt_q};
        end
        else if (iefl_hit(req.adr, `IEFL_OFF_STAT))
        begin
            rd_d = {`IEFL_ZERO24, `IEFL_ZERO5, ev_stat_q};
        end
        else if (iefl_hit(req.adr, `IEFL_OFF_MASK))
        begin
            rd_d = {`IEFL_ZERO24, `IEFL_ZERO5, ev_mask_q};
        end
    end

    // Bus answer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= `IEFL_ZERO32;
        end
        else
        begin
            ack_o <= acc;
            if (acc && !req.we)
            begin
                dat_o <= rd_d;
            end
        end
    end

endmodule // iefl_top

// file: iefl_top_properties.sv
// Concurrent checks on the interrupt enable and flag block ports
`timescale 1ns/1ns
module iefl_chk
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic irq_take_i,
    input wire logic irq_return_i,
    input wire logic [12:0] return_addr_i,
    input wire logic core_irq_o,
    input wire logic stack_push_o,
    input wire logic [12:0] stack_push_addr_o,
    input wire logic pc_load_o,
    input wire logic [12:0] pc_vector_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing");
    chk_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack too long");
    chk_take_vector: assert property (
        stack_push_o |-> pc_load_o && pc_vector_o == 13'h0004)
        else $error("vector wrong");
    chk_take_cause: assert property (
        $rose(stack_push_o) |-> $past(irq_take_i) && $past(core_irq_o))
        else $error("take without request");
    chk_push_addr: assert property (
        stack_push_o |-> stack_push_addr_o == $past(return_addr_i))
        else $error("pushed address wrong");
    chk_push_single: assert property (stack_push_o |=> !stack_push_o)
        else $error("push too long");
    chk_gie_cleared: assert property (
        stack_push_o && !irq_return_i |=> !core_irq_o)
        else $error("request after take");
    chk_unmapped_zero: assert property (
        ack_o && !$past(we_i) && $past(adr_i) == 8'h20 |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_pen1_upper: assert property (
        ack_o && !$past(we_i) && $past(adr_i) == 8'h04 |-> dat_o[31:6] == 26'h0)
        else $error("upper enable bits set");
endmodule // iefl_chk

bind iefl_top iefl_chk chk_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .dat_o, .ack_o, .irq_take_i, .irq_return_i, .return_addr_i, .core_irq_o,
    .stack_push_o, .stack_push_addr_o, .pc_load_o, .pc_vector_o);

// file: test_iefl_top.sv
// Self-checking bench for the interrupt enable and flag block
`timescale 1ns/1ns
`include "iefl_defs.svh"
module test_iefl_top;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic timer0_tick_i = 1'b0, ext_pin_i = 1'b0, ext_edge_rising_i = 1'b1;
    logic irq_take_i = 1'b0, irq_return_i = 1'b0, ack_o, core_irq_o, irq_o;
    logic stack_push_o, pc_load_o;
    logic [7:0] adr_i = 8'h00, pin_change_pins_i = 8'h00;
    logic [3:0] sel_i = 4'h1;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic [5:0] periph_flags_i = 6'h00;
    logic [12:0] return_addr_i = 13'h0abc, stack_push_addr_o, pc_vector_o;
    int n_errors = 0, n_tests = 0;
    always #5 clk_i = ~clk_i;
    iefl_top dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .timer0_tick_i, .ext_pin_i, .ext_edge_rising_i,
        .pin_change_pins_i, .periph_flags_i, .irq_take_i, .irq_return_i,
        .return_addr_i, .core_irq_o, .stack_push_o, .stack_push_addr_o,
        .pc_load_o, .pc_vector_o, .irq_o);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic t_regs;
        wb(0, `IEFL_OFF_CTRL, 0);
        chk(rd, 32'h0);
        wb(1, `IEFL_OFF_PEN1, 32'hff);
        wb(0, `IEFL_OFF_PEN1, 0);
        chk(rd, 32'h3f);
        sel_i <= 4'h0;
        wb(1, `IEFL_OFF_PEN1, 32'h00);
        sel_i <= 4'h1;
        wb(0, `IEFL_OFF_PEN1, 0);
        chk(rd, 32'h3f);
        wb(1, 8'h20, 32'h5a);
        wb(0, 8'h20, 0);
        chk(rd, 32'h0);
        $display("regs done");
    endtask
    task automatic t_periph;
        wb(1, `IEFL_OFF_CTRL, 32'hc0);
        for (int i = 0; i < 6; i++)
        begin
            wb(1, `IEFL_OFF_PEN1, 32'h1 << i);
            periph_flags_i <= 6'h3f ^ (6'h1 << i);
            repeat (3) @(posedge clk_i);
            chk(32'(core_irq_o), 32'h0);
            periph_flags_i <= 6'h1 << i;
            repeat (3) @(posedge clk_i);
            chk(32'(core_irq_o), 32'h1);
        end
        wb(1, `IEFL_OFF_CTRL, 32'h80);
        repeat (3) @(posedge clk_i);
        chk(32'(core_irq_o), 32'h0);
        periph_flags_i <= 6'h00;
        wb(1, `IEFL_OFF_CTRL, 0);
        $display("periph done");
    endtask
    task automatic t_timer;
        wb(1, `IEFL_OFF_MASK, 32'h1);
        wb(1, `IEFL_OFF_TCNT, 32'hff);
        @(posedge clk_i) timer0_tick_i <= 1'b1;
        @(posedge clk_i) timer0_tick_i <= 1'b0;
        wb(0, `IEFL_OFF_CTRL, 0);
        chk(rd, 32'h04);
        chk(32'(irq_o), 32'h1);
        wb(0, `IEFL_OFF_TCNT, 0);
        chk(rd, 32'h0);
        wb(1, `IEFL_OFF_CTRL, 0);
        wb(0, `IEFL_OFF_CTRL, 0);
        chk(rd, 32'h0);
        wb(1, `IEFL_OFF_MASK, 0);
        wb(0, `IEFL_OFF_STAT, 0);
        chk(rd, 32'h1);
        chk(32'(irq_o), 32'h0);
        wb(1, `IEFL_OFF_STAT, 32'h1);
        wb(0, `IEFL_OFF_STAT, 0);
        chk(rd, 32'h0);
        $display("timer done");
    endtask
    task automatic t_ext;
        @(posedge clk_i) ext_pin_i <= 1'b1;
        wb(0, `IEFL_OFF_CTRL, 0);
        chk(rd, 32'h02);
        wb(1, `IEFL_OFF_CTRL, 0);
        @(posedge clk_i) ext_pin_i <= 1'b0;
        wb(0, `IEFL_OFF_CTRL, 0);
        chk(rd, 32'h0);
        @(posedge clk_i) ext_edge_rising_i <= 1'b0;
        @(posedge clk_i) ext_pin_i <= 1'b1;
        wb(0, `IEFL_OFF_CTRL, 0);
        chk(rd, 32'h0);
        @(posedge clk_i) ext_pin_i <= 1'b0;
        wb(0, `IEFL_OFF_CTRL, 0);
        chk(rd, 32'h02);
        wb(1, `IEFL_OFF_CTRL, 32'h92);
        repeat (3) @(posedge clk_i);
        chk(32'(core_irq_o), 32'h1);
        wb(1, `IEFL_OFF_CTRL, 32'h82);
        repeat (3) @(posedge clk_i);
        chk(32'(core_irq_o), 32'h0);
        wb(1, `IEFL_OFF_CTRL, 0);
        @(posedge clk_i) pin_change_pins_i <= 8'h02;
        wb(0, `IEFL_OFF_CTRL, 0);
        chk(rd, 32'h0);
        wb(1, `IEFL_OFF_PSEL, 32'h1);
        @(posedge clk_i) pin_change_pins_i <= 8'h03;
        wb(0, `IEFL_OFF_CTRL, 0);
        chk(rd, 32'h01);
        wb(1, `IEFL_OFF_CTRL, 32'h89);
        repeat (3) @(posedge clk_i);
        chk(32'(core_irq_o), 32'h1);
        wb(1, `IEFL_OFF_CTRL, 32'h81);
        repeat (3) @(posedge clk_i);
        chk(32'(core_irq_o), 32'h0);
        wb(1, `IEFL_OFF_CTRL, 0);
        wb(1, `IEFL_OFF_STAT, 32'h7);
        $display("ext done");
    endtask
    task automatic t_take;
        wb(1, `IEFL_OFF_CTRL, 0);
        wb(1, `IEFL_OFF_CTRL, 32'h24);
        repeat (3) @(posedge clk_i);
        chk(32'(core_irq_o), 32'h0);
        wb(1, `IEFL_OFF_CTRL, 32'h84);
        repeat (3) @(posedge clk_i);
        chk(32'(core_irq_o), 32'h0);
        wb(1, `IEFL_OFF_CTRL, 32'ha4);
        repeat (3) @(posedge clk_i);
        chk(32'(core_irq_o), 32'h1);
        @(posedge clk_i) irq_take_i <= 1'b1;
        @(posedge clk_i) irq_take_i <= 1'b0;
        @(posedge clk_i);
        chk(32'(stack_push_o), 32'h1);
        chk(32'(pc_vector_o), 32'h4);
        chk(32'(stack_push_addr_o), 32'h0abc);
        wb(0, `IEFL_OFF_CTRL, 0);
        chk(rd, 32'h24);
        @(posedge clk_i) irq_return_i <= 1'b1;
        @(posedge clk_i) irq_return_i <= 1'b0;
        wb(0, `IEFL_OFF_CTRL, 0);
        chk(rd, 32'ha4);
        wb(1, `IEFL_OFF_TCNT, 32'h37);
        @(posedge clk_i) rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, `IEFL_OFF_CTRL, 0);
        chk(rd, 32'h0);
        wb(0, `IEFL_OFF_TCNT, 0);
        chk(rd, 32'h37);
        $display("take done");
    endtask
    task automatic complete_run;
        $display("%0d compares, %0d mismatches", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_periph;
        t_timer;
        t_ext;
        t_take;
        complete_run;
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        complete_run;
    end
endmodule // test_iefl_top
